// file: hw/sirq_pkg.sv
// constants for the system clock, infrared control and interrupt flag register bank
package sirq_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   // register addresses
   localparam logic [5:0] SYS_CLK_MODE_ADDR = 6'h0D;
   localparam logic [5:0] IR_PIN_CTRL_ADDR = 6'h0E;
   localparam logic [5:0] IRQ_FLAGS_ADDR = 6'h0F;
   localparam logic [5:0] IRQ_MASK_ADDR = 6'h0B;
   localparam logic [5:0] MODE_CMD_ADDR = 6'h0C;
   localparam logic [5:0] GPR_FIRST_ADDR = 6'h10;
   localparam logic [5:0] GPR_LAST_ADDR = 6'h3F;
   localparam int GPR_BANKS = 4;
   // system clock mode control fields
   localparam int PLL_HI_BIT = 6;
   localparam int PLL_LO_BIT = 4;
   localparam int IDLE_SEL_BIT = 3;
   localparam int BOOST_HI_BIT = 2;
   localparam int BOOST_LO_BIT = 1;
   localparam int CPU_SRC_BIT = 0;
   localparam logic [7:0] SYS_CLK_MODE_MASK = 8'h7F;
   // infrared pin function control fields
   localparam int IR_EN_BIT = 7;
   localparam int CARRIER_BIT = 6;
   localparam int LOW_ONLY_BIT = 5;
   localparam int IR_PIN_SEL_BIT = 3;
   localparam int CNT_PIN_SEL_BIT = 2;
   localparam int EXT1_SEL_BIT = 1;
   localparam int EXT0_SEL_BIT = 0;
   localparam logic [7:0] IR_PIN_CTRL_MASK = 8'hEF;
   // mode command codes
   localparam logic [7:0] CMD_POWER_DOWN = 8'h01;
   localparam logic [7:0] CMD_WAKE = 8'h02;
   localparam logic [7:0] CMD_GREEN = 8'h03;
   // pll multiplier codes (main clock = sub clock * factor / 4)
   localparam logic [9:0] PLL_X130 = 10'h208;
   localparam logic [9:0] PLL_X65 = 10'h104;
   localparam logic [9:0] PLL_X65_2 = 10'h082;
   localparam logic [9:0] PLL_X65_4 = 10'h041;
   localparam logic [9:0] PLL_X244 = 10'h3D0;
   // booster divider values
   localparam logic [4:0] BOOST_DIV1 = 5'h01;
   localparam logic [4:0] BOOST_DIV4 = 5'h04;
   localparam logic [4:0] BOOST_DIV8 = 5'h08;
   localparam logic [4:0] BOOST_DIV16 = 5'h10;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int RESET_WAIT_MS = 18;
   localparam int RESET_WAIT_CYC = RESET_WAIT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SUB_PERIODS = 15;
   localparam int MAIN_PERIODS = 11;
   typedef enum logic [4:0] {
      SIRQ_NORMAL = 5'h01,
      SIRQ_GREEN = 5'h02,
      SIRQ_IDLE = 5'h04,
      SIRQ_SLEEP = 5'h08,
      SIRQ_WAKE = 5'h10
   } sirq_mode_t;
endpackage

// file: hw/sirq_regs.sv
// system clock, infrared pin control and interrupt flag register bank
//
// Operation
// - pll field picks main clock factor 130, 65, 65/2, 65/4 or 244
// - power-down enters idle when idle bit set, else sleep
// - booster field divides sub clock by 1, 4, 8 or 16
// - cpu source bit 0 runs sub clock and stops main oscillator
// - with watchdog on, sub-clock timers stop in sleep
// - pin-clocked timer counts in sleep and flags, but never wakes
// - main-clock timers halt in sleep or green until normal runs
// - wake to normal waits start time plus 11 main from green, or plus 15 sub (and 18 ms more from sleep)
// - any reset delays 18 ms plus start time plus 15 sub periods
// - wake to green waits start time plus 15 sub, plus 18 ms from sleep
// - infrared enable starts generator; off, pin follows port settings
// - carrier bit 0 gives plain pwm, counter two independent
// - carrier bit 1 modulates low sections with counter two carrier
// - low-only bit ignores high width timer
// - output select drives infrared wave on port 5 bit 7 while its port direction is output
// - counter input select makes port 5 bit 6 the counter clock
// - external interrupt selects let the two external pin inputs set flags 2 and 1
// - flag bit 7 sets on port 6 or 8 input change
// - flags 6..3 set on low, high, counter two, counter one underflow
// - flags 2, 1 external pins; flag 0 timer overflow
// - addresses 10h to 3Fh hold banked general registers
// - mask register enables each flag source by bit
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module sirq_regs
   import sirq_pkg::*;
#(
   parameter int RESET_WAIT = RESET_WAIT_CYC,
   parameter int OSC_START = 64,
   parameter int SUB_DIV = 3815,
   parameter int MAIN_DIV = 16
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   // register port
   input wire logic [ADDR_W-1:0] ADDR_IN,
   input wire logic [DATA_W-1:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [1:0] BANK_IN,
   output logic [DATA_W-1:0] RDATA_OUT,
   // event inputs
   input wire logic PORT_CHANGE_IN,
   input wire logic LOW_UFL_IN,
   input wire logic HIGH_UFL_IN,
   input wire logic CNT2_UFL_IN,
   input wire logic CNT1_UFL_IN,
   input wire logic EXT1_IN,
   input wire logic EXT0_IN,
   input wire logic TCC_OVF_IN,
   input wire logic WDT_EN_IN,
   input wire logic IR_WAVE_IN,
   input wire logic CARRIER_IN,
   input wire logic PORT57_DATA_IN,
   input wire logic PORT57_DIR_IN,
   // control outputs
   output logic [9:0] PLL_FACTOR_OUT,
   output logic [4:0] BOOST_DIV_OUT,
   output logic CPU_MAIN_OUT,
   output logic MAIN_OSC_EN_OUT,
   output logic [4:0] MODE_OUT,
   output logic CPU_RUN_OUT,
   output logic SUB_TMR_RUN_OUT,
   output logic MAIN_TMR_RUN_OUT,
   output logic CNT2_FREE_OUT,
   output logic HIGH_TMR_USE_OUT,
   output logic P57_OUT,
   output logic P57_OE_OUT,
   output logic TCC_CLK_OUT,
   output logic [7:0] IRQ_PEND_OUT
);
   // ****************************************
   // reset synchroniser
   // ****************************************
   logic rst_s1_r, rst_r;
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         rst_s1_r <= 1'b0;
         rst_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_r <= rst_s1_r;
      end
   end
   wire logic rstn = rst_r;

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] sys_r, irc_r, flags_r, mask_r, flags_nxt;
   logic [7:0] gpr_r [GPR_BANKS][GPR_LAST_ADDR - GPR_FIRST_ADDR + 6'h01];
   logic [7:0] events;
   wire logic wr_sys = WR_IN && ADDR_IN == SYS_CLK_MODE_ADDR;
   wire logic wr_irc = WR_IN && ADDR_IN == IR_PIN_CTRL_ADDR;
   wire logic wr_flg = WR_IN && ADDR_IN == IRQ_FLAGS_ADDR;
   wire logic wr_msk = WR_IN && ADDR_IN == IRQ_MASK_ADDR;
   wire logic wr_cmd = WR_IN && ADDR_IN == MODE_CMD_ADDR;
   wire logic in_gpr = ADDR_IN >= GPR_FIRST_ADDR;
   wire logic [5:0] gidx = ADDR_IN - GPR_FIRST_ADDR;
   sirq_mode_t mode_r;

   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         sys_r <= 8'h00;
         irc_r <= 8'h00;
         mask_r <= 8'h00;
      end else begin
         if (wr_sys) begin
            sys_r <= WDATA_IN & SYS_CLK_MODE_MASK;
         end
         if (wr_irc) begin
            irc_r <= WDATA_IN & IR_PIN_CTRL_MASK;
         end
         if (wr_msk) begin
            mask_r <= WDATA_IN;
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (WR_IN && in_gpr) begin
         gpr_r[BANK_IN][gidx] <= WDATA_IN;
      end
   end

   // ****************************************
   // interrupt flags
   // ****************************************
   always_comb begin
      events = {PORT_CHANGE_IN,
                LOW_UFL_IN, HIGH_UFL_IN, CNT2_UFL_IN, CNT1_UFL_IN,
                EXT1_IN && irc_r[EXT1_SEL_BIT],
                EXT0_IN && irc_r[EXT0_SEL_BIT],
                TCC_OVF_IN};
      // sub-clock timers are frozen while asleep with the watchdog on
      if (mode_r == SIRQ_SLEEP && WDT_EN_IN) begin
         events[6:3] = 4'h0;
      end
      flags_nxt = flags_r;
      if (wr_flg) begin
         flags_nxt = flags_r & WDATA_IN;
      end
      flags_nxt = flags_nxt | events; // set wins over clear
   end

   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         flags_r <= 8'h00;
         IRQ_PEND_OUT <= 8'h00;
      end else begin
         flags_r <= flags_nxt;
         IRQ_PEND_OUT <= flags_nxt & mask_r;
      end
   end

   // ****************************************
   // operating mode and wake timing
   // ****************************************
   logic [31:0] wait_r;
   sirq_mode_t target_r;
   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         mode_r <= SIRQ_WAKE;
         target_r <= SIRQ_NORMAL;
         wait_r <= 32'(RESET_WAIT + OSC_START + SUB_PERIODS * SUB_DIV);
      end else begin
         unique case (mode_r)
            SIRQ_NORMAL, SIRQ_GREEN: begin
               if (wr_cmd && WDATA_IN == CMD_POWER_DOWN) begin
                  mode_r <= sys_r[IDLE_SEL_BIT] ? SIRQ_IDLE : SIRQ_SLEEP;
               end else if (mode_r == SIRQ_GREEN && sys_r[CPU_SRC_BIT]) begin
                  mode_r <= SIRQ_WAKE;
                  target_r <= SIRQ_NORMAL;
                  wait_r <= 32'(OSC_START + MAIN_PERIODS * MAIN_DIV);
               end else if (mode_r == SIRQ_NORMAL && !sys_r[CPU_SRC_BIT]) begin
                  mode_r <= SIRQ_GREEN;
               end
            end
            SIRQ_IDLE, SIRQ_SLEEP: begin
               // pin-clocked timer events never wake the cpu
               if (wr_cmd && (WDATA_IN == CMD_WAKE || WDATA_IN == CMD_GREEN)) begin
                  mode_r <= SIRQ_WAKE;
                  target_r <= WDATA_IN == CMD_WAKE ? SIRQ_NORMAL : SIRQ_GREEN;
                  wait_r <= 32'(OSC_START + SUB_PERIODS * SUB_DIV
                     + (mode_r == SIRQ_SLEEP ? RESET_WAIT : 0));
               end
            end
            SIRQ_WAKE: begin
               if (wait_r == 32'h0) begin
                  mode_r <= target_r;
               end else begin
                  wait_r <= wait_r - 32'h1;
               end
            end
         endcase
      end
   end

   // ****************************************
   // clock, pin and timer outputs
   // ****************************************
   function automatic logic [9:0] pll_factor(input logic [2:0] code);
      if (code[2]) begin
         return PLL_X244;
      end
      unique case (code[1:0])
         2'b00: return PLL_X130;
         2'b01: return PLL_X65;
         2'b10: return PLL_X65_2;
         default: return PLL_X65_4;
      endcase
   endfunction

   logic [4:0] boost;
   always_comb begin
      unique case (sys_r[BOOST_HI_BIT:BOOST_LO_BIT])
         2'b00: boost = BOOST_DIV1;
         2'b01: boost = BOOST_DIV4;
         2'b10: boost = BOOST_DIV8;
         default: boost = BOOST_DIV16;
      endcase
   end

   wire logic ir_on = irc_r[IR_EN_BIT];
   wire logic hf = irc_r[CARRIER_BIT];
   wire logic ir_level = IR_WAVE_IN | (hf & CARRIER_IN & ~IR_WAVE_IN);

   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         PLL_FACTOR_OUT <= PLL_X130;
         BOOST_DIV_OUT <= BOOST_DIV1;
         CPU_MAIN_OUT <= 1'b0;
         MAIN_OSC_EN_OUT <= 1'b0;
         MODE_OUT <= SIRQ_WAKE;
         CPU_RUN_OUT <= 1'b0;
         SUB_TMR_RUN_OUT <= 1'b0;
         MAIN_TMR_RUN_OUT <= 1'b0;
         CNT2_FREE_OUT <= 1'b1;
         HIGH_TMR_USE_OUT <= 1'b1;
         P57_OUT <= 1'b0;
         P57_OE_OUT <= 1'b0;
         TCC_CLK_OUT <= 1'b0;
      end else begin
         PLL_FACTOR_OUT <= pll_factor(sys_r[PLL_HI_BIT:PLL_LO_BIT]);
         BOOST_DIV_OUT <= boost;
         CPU_MAIN_OUT <= sys_r[CPU_SRC_BIT];
         MAIN_OSC_EN_OUT <= sys_r[CPU_SRC_BIT];
         MODE_OUT <= mode_r;
         CPU_RUN_OUT <= mode_r == SIRQ_NORMAL || mode_r == SIRQ_GREEN;
         SUB_TMR_RUN_OUT <= !(mode_r == SIRQ_SLEEP && WDT_EN_IN) && mode_r != SIRQ_WAKE;
         MAIN_TMR_RUN_OUT <= mode_r == SIRQ_NORMAL;
         CNT2_FREE_OUT <= !(ir_on && hf);
         HIGH_TMR_USE_OUT <= !irc_r[LOW_ONLY_BIT];
         if (ir_on && irc_r[IR_PIN_SEL_BIT]) begin
            P57_OUT <= ir_level;
            P57_OE_OUT <= !PORT57_DIR_IN;
         end else begin
            P57_OUT <= PORT57_DATA_IN;
            P57_OE_OUT <= !PORT57_DIR_IN;
         end
         TCC_CLK_OUT <= irc_r[CNT_PIN_SEL_BIT];
      end
   end

   // ****************************************
   // read port
   // ****************************************
   always_ff @(posedge CLK_IN or negedge rstn) begin
      if (!rstn) begin
         RDATA_OUT <= 8'h00;
      end else if (RD_IN) begin
         if (in_gpr) begin
            RDATA_OUT <= gpr_r[BANK_IN][gidx];
         end else begin
            unique case (ADDR_IN)
               SYS_CLK_MODE_ADDR: RDATA_OUT <= sys_r;
               IR_PIN_CTRL_ADDR: RDATA_OUT <= irc_r;
               IRQ_FLAGS_ADDR: RDATA_OUT <= flags_r;
               IRQ_MASK_ADDR: RDATA_OUT <= mask_r;
               MODE_CMD_ADDR: RDATA_OUT <= {3'h0, mode_r};
               default: RDATA_OUT <= 8'h00;
            endcase
         end
      end else begin
         RDATA_OUT <= 8'h00;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_flag_hold;
      @(posedge CLK_IN) disable iff (!rstn)
      (flags_r[0] && !(wr_flg && !WDATA_IN[0])) |=> flags_r[0];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

   property p_flag_set;
      @(posedge CLK_IN) disable iff (!rstn)
      PORT_CHANGE_IN |=> flags_r[7];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("change flag not set");

   property p_mask;
      @(posedge CLK_IN) disable iff (!rstn)
      ##1 IRQ_PEND_OUT == (flags_r & $past(mask_r));
   endproperty
   a_mask: assert property (p_mask) else $error("mask gating wrong");

   property p_idle;
      @(posedge CLK_IN) disable iff (!rstn)
      (mode_r == SIRQ_NORMAL && wr_cmd && WDATA_IN == CMD_POWER_DOWN && sys_r[IDLE_SEL_BIT])
      |=> mode_r == SIRQ_IDLE;
   endproperty
   a_idle: assert property (p_idle) else $error("idle not entered");

   property p_main_tmr;
      @(posedge CLK_IN) disable iff (!rstn)
      (mode_r == SIRQ_SLEEP) |=> !MAIN_TMR_RUN_OUT;
   endproperty
   a_main_tmr: assert property (p_main_tmr) else $error("main timer ran");

   property p_low_only;
      @(posedge CLK_IN) disable iff (!rstn)
      irc_r[LOW_ONLY_BIT] |=> !HIGH_TMR_USE_OUT;
   endproperty
   a_low_only: assert property (p_low_only) else $error("high timer used");

   property p_tcc;
      @(posedge CLK_IN) disable iff (!rstn)
      irc_r[CNT_PIN_SEL_BIT] |=> TCC_CLK_OUT;
   endproperty
   a_tcc: assert property (p_tcc) else $error("counter pin not selected");

   property p_cpu_src;
      @(posedge CLK_IN) disable iff (!rstn)
      !sys_r[CPU_SRC_BIT] |=> !MAIN_OSC_EN_OUT && !CPU_MAIN_OUT;
   endproperty
   a_cpu_src: assert property (p_cpu_src) else $error("main oscillator running");
endmodule
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the clock, infrared and interrupt flag register bank
`timescale 1ns/10ps
`default_nettype none
module tb
   import sirq_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] bank = 2'h0;
   logic [7:0] ev = 8'h00;
   logic wdt = 1'b0;
   logic wave = 1'b0;
   logic car = 1'b0;
   logic pdat = 1'b0;
   logic pdir = 1'b0;
   logic [7:0] rdata;
   logic [9:0] pll;
   logic [4:0] bdiv;
   logic [4:0] mode;
   logic cmain, osc, crun, srun, mrun, c2f, hiu, p57, p57oe, timer_clock_counter;
   logic [7:0] pend;
   int n_errors = 0;
   int n_checks = 0;
   int n;

   initial begin
      forever #4 clk = ~clk;
   end

   sirq_regs #(.RESET_WAIT(10), .OSC_START(4), .SUB_DIV(2), .MAIN_DIV(2)) i_dut (
      .CLK_IN(clk), .RESETN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
      .RD_IN(rd), .BANK_IN(bank), .RDATA_OUT(rdata), .PORT_CHANGE_IN(ev[7]),
      .LOW_UFL_IN(ev[6]), .HIGH_UFL_IN(ev[5]), .CNT2_UFL_IN(ev[4]), .CNT1_UFL_IN(ev[3]),
      .EXT1_IN(ev[2]), .EXT0_IN(ev[1]), .TCC_OVF_IN(ev[0]), .WDT_EN_IN(wdt),
      .IR_WAVE_IN(wave), .CARRIER_IN(car), .PORT57_DATA_IN(pdat), .PORT57_DIR_IN(pdir),
      .PLL_FACTOR_OUT(pll), .BOOST_DIV_OUT(bdiv), .CPU_MAIN_OUT(cmain),
      .MAIN_OSC_EN_OUT(osc), .MODE_OUT(mode), .CPU_RUN_OUT(crun), .SUB_TMR_RUN_OUT(srun),
      .MAIN_TMR_RUN_OUT(mrun), .CNT2_FREE_OUT(c2f), .HIGH_TMR_USE_OUT(hiu), .P57_OUT(p57),
      .P57_OE_OUT(p57oe), .TCC_CLK_OUT(timer_clock_counter), .IRQ_PEND_OUT(pend));

   // ************************************
   // bus, wait and compare tasks
   // ************************************
   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      tick(1);
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({2'h0, rdata}, {2'h0, e});
   endtask

   task automatic pulse(input logic [7:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 8'h00;
      tick(1);
   endtask

   task automatic drv(input logic w, input logic c, input logic d, input logic r);
      @(posedge clk);
      wave <= w;
      car <= c;
      pdat <= d;
      pdir <= r;
      tick(2);
   endtask

   task automatic wait_mode(input logic [4:0] m, output int k);
      k = 0;
      #1;
      while (mode !== m) begin
         tick(1);
         k++;
         if (k > 500) begin
            n_errors++;
            stop_test();
         end
      end
   endtask

   // ************************************
   // scenarios
   // ************************************
   task automatic t_fields;
      logic [9:0] pf [8];
      logic [4:0] bd [4];
      pf = '{PLL_X130, PLL_X65, PLL_X65_2, PLL_X65_4, PLL_X244, PLL_X244, PLL_X244, PLL_X244};
      bd = '{BOOST_DIV1, BOOST_DIV4, BOOST_DIV8, BOOST_DIV16};
      for (int i = 0; i < 8; i++) begin
         wr_reg(SYS_CLK_MODE_ADDR, {1'b1, i[2:0], 1'b0, i[1:0], 1'b0});
         chk(pll, pf[i]);
         chk(10'(bdiv), 10'(bd[i[1:0]]));
         rd_chk(SYS_CLK_MODE_ADDR, {1'b0, i[2:0], 1'b0, i[1:0], 1'b0});
      end
   endtask

   task automatic t_infrared;
      wr_reg(IR_PIN_CTRL_ADDR, 8'hFF);
      rd_chk(IR_PIN_CTRL_ADDR, 8'hEF);
      chk(10'(timer_clock_counter), 10'h001);
      wr_reg(IR_PIN_CTRL_ADDR, 8'h88);
      drv(1'b1, 1'b0, 1'b0, 1'b0);
      chk(10'({p57, p57oe}), 10'h003);
      chk(10'({c2f, hiu}), 10'h003);
      chk(10'(timer_clock_counter), 10'h000);
      drv(1'b0, 1'b1, 1'b0, 1'b0);
      chk(10'(p57), 10'h000);
      wr_reg(IR_PIN_CTRL_ADDR, 8'hA8);
      chk(10'(hiu), 10'h000);
      wr_reg(IR_PIN_CTRL_ADDR, 8'hC8);
      chk(10'(c2f), 10'h000);
      chk(10'(p57), 10'h001);
      drv(1'b0, 1'b0, 1'b0, 1'b0);
      chk(10'(p57), 10'h000);
      drv(1'b1, 1'b0, 1'b0, 1'b0);
      chk(10'(p57), 10'h001);
      wr_reg(IR_PIN_CTRL_ADDR, 8'h00);
      drv(1'b0, 1'b0, 1'b1, 1'b0);
      chk(10'({p57, p57oe}), 10'h003);
      drv(1'b1, 1'b0, 1'b1, 1'b1);
      chk(10'(p57oe), 10'h000);
   endtask

   task automatic t_flags;
      pulse(8'h06);
      rd_chk(IRQ_FLAGS_ADDR, 8'h00);
      wr_reg(IR_PIN_CTRL_ADDR, 8'h03);
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i);
         rd_chk(IRQ_FLAGS_ADDR, 8'h01 << i);
         wr_reg(IRQ_FLAGS_ADDR, ~(8'h01 << i));
         rd_chk(IRQ_FLAGS_ADDR, 8'h00);
      end
      // event and clear in one cycle: the event wins
      @(posedge clk);
      ev <= 8'h01;
      addr <= IRQ_FLAGS_ADDR;
      wdata <= 8'h00;
      wr <= 1'b1;
      @(posedge clk);
      ev <= 8'h00;
      wr <= 1'b0;
      rd_chk(IRQ_FLAGS_ADDR, 8'h01);
      wr_reg(IRQ_FLAGS_ADDR, 8'h00);
      pulse(8'hFF);
      wr_reg(IRQ_FLAGS_ADDR, 8'hFF);
      rd_chk(IRQ_FLAGS_ADDR, 8'hFF);
      wr_reg(IRQ_MASK_ADDR, 8'h5A);
      rd_chk(IRQ_MASK_ADDR, 8'h5A);
      chk(10'(pend), 10'h05A);
      wr_reg(IRQ_FLAGS_ADDR, 8'h0F);
      tick(1);
      chk(10'(pend), 10'h00A);
      wr_reg(IRQ_FLAGS_ADDR, 8'h00);
   endtask

   task automatic t_general;
      for (int b = 0; b < 4; b++) begin
         @(posedge clk);
         bank <= b[1:0];
         wr_reg(GPR_FIRST_ADDR, 8'hA0 | 8'(b));
         wr_reg(GPR_LAST_ADDR, 8'h50 | 8'(b));
      end
      for (int b = 0; b < 4; b++) begin
         @(posedge clk);
         bank <= b[1:0];
         rd_chk(GPR_FIRST_ADDR, 8'hA0 | 8'(b));
         rd_chk(GPR_LAST_ADDR, 8'h50 | 8'(b));
      end
      wr_reg(6'h00, 8'hFF);
      rd_chk(6'h00, 8'h00);
   endtask

   task automatic t_modes;
      wr_reg(SYS_CLK_MODE_ADDR, 8'h08);
      wr_reg(MODE_CMD_ADDR, CMD_POWER_DOWN);
      tick(1);
      chk(10'(mode), 10'(SIRQ_IDLE));
      chk(10'({crun, osc}), 10'h000);
      wr_reg(MODE_CMD_ADDR, CMD_GREEN);
      wait_mode(SIRQ_GREEN, n);
      chk_rng(n, 30, 38);
      chk(10'(mrun), 10'h000);
      wr_reg(SYS_CLK_MODE_ADDR, 8'h01);
      wait_mode(SIRQ_NORMAL, n);
      chk_rng(n, 22, 30);
      chk(10'({cmain, osc, mrun}), 10'h007);
      @(posedge clk);
      wdt <= 1'b1;
      wr_reg(MODE_CMD_ADDR, CMD_POWER_DOWN);
      tick(1);
      chk(10'(mode), 10'(SIRQ_SLEEP));
      chk(10'({srun, mrun}), 10'h000);
      pulse(8'h41);
      tick(2);
      chk(10'({mode, crun}), 10'({SIRQ_SLEEP, 1'b0}));
      rd_chk(IRQ_FLAGS_ADDR, 8'h01);
      wr_reg(MODE_CMD_ADDR, CMD_WAKE);
      wait_mode(SIRQ_NORMAL, n);
      chk_rng(n, 40, 48);
      wr_reg(SYS_CLK_MODE_ADDR, 8'h09);
      wr_reg(MODE_CMD_ADDR, CMD_POWER_DOWN);
      tick(1);
      chk(10'(mode), 10'(SIRQ_IDLE));
      wr_reg(MODE_CMD_ADDR, CMD_WAKE);
      wait_mode(SIRQ_NORMAL, n);
      chk_rng(n, 30, 38);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      #1;
      chk(pll, PLL_X130);
      chk(10'({bdiv, mode}), 10'({BOOST_DIV1, SIRQ_WAKE}));
      @(posedge clk);
      rstn <= 1'b1;
      wait_mode(SIRQ_NORMAL, n);
      chk_rng(n, 42, 49);
      rd_chk(IRQ_FLAGS_ADDR, 8'h00);
      t_fields();
      t_infrared();
      t_flags();
      t_general();
      t_modes();
      stop_test();
   end
endmodule
`default_nettype wire
